//--- core/rf_flags_pkg.sv
package rf_flags_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_UID_LO   = 8'h04;
  localparam logic [7:0] OFF_UID_HI   = 8'h08;
  localparam logic [7:0] OFF_REQ      = 8'h0c;
  localparam logic [7:0] OFF_DECODE   = 8'h10;
  localparam logic [7:0] OFF_INT_STAT = 8'h14;
  localparam logic [7:0] OFF_INT_MASK = 8'h18;
  localparam logic [7:0] OFF_RESP     = 8'h1c;

  // Request flag bit positions, bit 1 of the byte is index 0
  localparam int BIT_SUBCARRIER = 0;
  localparam int BIT_RATE       = 1;
  localparam int BIT_INVENTORY  = 2;
  localparam int BIT_EXTENSION  = 3;
  localparam int BIT_SEL_AFI    = 4;
  localparam int BIT_ADDR_SLOTS = 5;
  localparam int BIT_OPTION     = 6;

  // Response flag byte
  localparam int         RESP_ERROR_BIT = 0;
  localparam logic [7:0] RESP_OK_BYTE   = 8'h00;
  localparam logic [7:0] RESP_ERR_BYTE  = 8'h01;

  // Error codes
  localparam logic [7:0] ERR_UNKNOWN_CMD   = 8'h02;
  localparam logic [7:0] ERR_NO_OPTION     = 8'h03;
  localparam logic [7:0] ERR_UNSPECIFIED   = 8'h0f;
  localparam logic [7:0] ERR_BLOCK_NA      = 8'h10;
  localparam logic [7:0] ERR_ALREADY_LOCK  = 8'h11;
  localparam logic [7:0] ERR_BLOCK_LOCKED  = 8'h12;
  localparam logic [7:0] ERR_PROG_FAIL     = 8'h13;
  localparam logic [7:0] ERR_LOCK_FAIL     = 8'h14;
  localparam logic [7:0] ERR_READ_PROT     = 8'h15;

  localparam int         UID_BYTES     = 8;
  localparam logic [2:0] UID_LAST_IDX  = 3'h7;
  localparam logic [2:0] SLOT_CNT_BITS = 3'h4;

  // Interrupt status bits
  localparam int IRQ_W      = 4;
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_SILENT = 1;
  localparam int IRQ_FORMAT = 2;
  localparam int IRQ_SENT   = 3;

  localparam logic [31:0]      CTRL_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;
  localparam logic [1:0]       RESP_OKAY   = 2'b00;
  localparam logic [1:0]       RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic subcarrierTwo;
    logic dataRateHigh;
    logic inventory;
    logic protocolExt;
    logic selectOnly;
    logic addressed;
    logic optionOn;
    logic family_id_present_bit;
    logic slot_count_bit;
  } req_flags_t;

endpackage

//--- core/rf_flag_decode.sv
`timescale 1ns/100ps
module rf_flag_decode (
  input  wire logic [7:0]              flagByte,
  output rf_flags_pkg::req_flags_t     flags
);
  import rf_flags_pkg::*;

  logic inv;
  assign inv = flagByte[BIT_INVENTORY];

  always_comb begin
    flags.subcarrierTwo         = flagByte[BIT_SUBCARRIER];
    flags.dataRateHigh          = flagByte[BIT_RATE];
    flags.inventory             = inv;
    flags.protocolExt           = flagByte[BIT_EXTENSION];
    flags.selectOnly            = !inv && flagByte[BIT_SEL_AFI];
    flags.addressed             = !inv && flagByte[BIT_ADDR_SLOTS];
    flags.family_id_present_bit = inv && flagByte[BIT_SEL_AFI];
    flags.slot_count_bit        = inv && flagByte[BIT_ADDR_SLOTS];
    // Top bit never looked at
    flags.optionOn              = !inv && flagByte[BIT_OPTION];
  end
endmodule

//--- core/resp_composer.sv
`timescale 1ns/100ps
module resp_composer (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic       isError,
  input  wire logic [7:0] errCode,
  input  wire logic       txReady,
  output logic            txValid,
  output logic [7:0]      txByte,
  output logic            txLast,
  output logic            busy
);
  import rf_flags_pkg::*;

  typedef enum logic [1:0] {C_IDLE, C_FLAGS, C_CODE} comp_state_t;
  comp_state_t state_q;
  logic [7:0]  code_q;

  // Flag byte first, then error code; no command code ever
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= C_IDLE;
      code_q  <= 8'h00;
      txValid <= 1'b0;
      txByte  <= 8'h00;
      txLast  <= 1'b0;
      busy    <= 1'b0;
    end else begin
      unique case (state_q)
        C_IDLE: if (start) begin
          state_q <= C_FLAGS;
          code_q  <= errCode;
          txValid <= 1'b1;
          txByte  <= isError ? RESP_ERR_BYTE : RESP_OK_BYTE;
          txLast  <= !isError;
          busy    <= 1'b1;
        end
        C_FLAGS: if (txReady) begin
          if (txLast) begin
            state_q <= C_IDLE;
            txValid <= 1'b0;
            txLast  <= 1'b0;
            busy    <= 1'b0;
          end else begin
            state_q <= C_CODE;
            txByte  <= code_q;
            txLast  <= 1'b1;
          end
        end
        C_CODE: if (txReady) begin
          state_q <= C_IDLE;
          txValid <= 1'b0;
          txLast  <= 1'b0;
          busy    <= 1'b0;
        end
      endcase
    end
  end

  property p_flagsUpperZero;
    @(posedge clock) disable iff (!rstn)
      state_q == C_FLAGS |-> txByte[7:1] == 7'h00;
  endproperty
  a_flagsUpperZero: assert property (p_flagsUpperZero)
    else $error("response flag upper bits not zero");

  property p_errorThenCode;
    @(posedge clock) disable iff (!rstn)
      state_q == C_FLAGS && txReady && txByte[RESP_ERROR_BIT]
        |=> txValid && txLast && txByte == code_q;
  endproperty
  a_errorThenCode: assert property (p_errorThenCode)
    else $error("error flag not followed by error code");

  property p_okSingleByte;
    @(posedge clock) disable iff (!rstn)
      state_q == C_FLAGS && !txByte[RESP_ERROR_BIT] |-> txLast;
  endproperty
  a_okSingleByte: assert property (p_okSingleByte)
    else $error("good response carries extra byte");

  c_errorResp: cover property (@(posedge clock) disable iff (!rstn)
    state_q == C_CODE && txReady);
endmodule

//--- core/rf_request_response_flags.sv
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
// What this block does
// - Request: flags, command, fields, checksum, delimiters; checksum bytes are ignored in P_PARAM, never checked
// - Flag byte steers actions and field presence
// - Flag byte is eight bits, bit 1 lowest
// - Bit 3 picks selection or inventory meaning
// - Bit 1 picks one or two subcarriers
// - Bit 2 picks low or high rate
// - Bit 4 flags extended protocol format
// - Select bit: only selected tag executes
// - Address bit: identifier present, must match
// - Inventory bit 5 marks family byte present
// - Inventory bit 6: sixteen slots or one
// - Response: flag byte, no command code
// - Response flag byte reports outcome, eight bits
// - Error bit set with appended error code
// - Fixed error code values
module rf_request_response_flags #(
  parameter int ADDR_W = 8
) (
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 rxSof,
  input  wire logic                 rxEof,
  input  wire logic                 rxValid,
  input  wire logic [7:0]           rxByte,
  output rf_flags_pkg::req_flags_t  reqFlags,
  output logic [7:0]                reqCommand,
  output logic                      reqDone,
  output logic                      reqExecute,
  input  wire logic                 txReady,
  output logic                      txValid,
  output logic [7:0]                txByte,
  output logic                      txLast,
  output logic                      irq
);
  import rf_flags_pkg::*;

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must be 8 to 32");
  end

  typedef enum logic [2:0] {P_IDLE, P_FLAGS, P_CMD, P_UID, P_AFI, P_PARAM} parse_t;

  parse_t           pstate_q;
  logic [7:0]       rawFlags_q;
  logic [7:0]       afi_q;
  logic [2:0]       uidIdx_q;
  logic             uidOk_q;
  logic [31:0]      ctrl_q, uidLo_q, uidHi_q;
  logic [IRQ_W-1:0] intStat_q, intMask_q, intEvt, intClr, intStat_d;
  logic             awHeld_q, wHeld_q, doWrite, startResp, txBusy;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0]      wData_q;
  logic [3:0]       wStrb_q;
  logic [63:0]      uid;
  logic             fmtErr, frameEnd, execNow;
  req_flags_t       curFlags;

  assign uid = {uidHi_q, uidLo_q};

  rf_flag_decode u_dec (
    .flagByte (rawFlags_q),
    .flags    (curFlags)
  );

  // Frame parser: fields arrive in fixed order after the start delimiter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pstate_q   <= P_IDLE;
      rawFlags_q <= 8'h00;
      reqCommand <= 8'h00;
      afi_q      <= 8'h00;
      uidIdx_q   <= 3'h0;
      uidOk_q    <= 1'b0;
    end else if (rxSof) begin
      pstate_q <= P_FLAGS;
    end else if (rxEof) begin
      pstate_q <= P_IDLE;
    end else if (rxValid) begin
      unique case (pstate_q)
        P_IDLE: ;
        P_FLAGS: begin
          rawFlags_q <= rxByte;
          pstate_q   <= P_CMD;
        end
        P_CMD: begin
          reqCommand <= rxByte;
          uidIdx_q   <= 3'h0;
          uidOk_q    <= 1'b1;
          if (curFlags.addressed)
            pstate_q <= P_UID;
          else if (curFlags.family_id_present_bit)
            pstate_q <= P_AFI;
          else
            pstate_q <= P_PARAM;
        end
        P_UID: begin
          // Identifier arrives low byte first
          uidOk_q  <= uidOk_q && (rxByte == uid[{uidIdx_q, 3'b000} +: 8]);
          uidIdx_q <= uidIdx_q + 3'h1;
          if (uidIdx_q == UID_LAST_IDX)
            pstate_q <= P_PARAM;
        end
        P_AFI: begin
          afi_q    <= rxByte;
          pstate_q <= P_PARAM;
        end
        P_PARAM: ;
      endcase
    end
  end

  // Truncated frame or select with address both set counts as malformed
  assign frameEnd = rxEof && !rxSof && pstate_q != P_IDLE;
  assign fmtErr   = pstate_q != P_PARAM
                 || (curFlags.selectOnly && rawFlags_q[BIT_ADDR_SLOTS]);
  assign execNow  = !fmtErr
                 && (curFlags.inventory
                     || (curFlags.selectOnly ? ctrl_q[0]
                         : (!curFlags.addressed || uidOk_q)));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reqDone    <= 1'b0;
      reqExecute <= 1'b0;
      reqFlags   <= '0;
    end else begin
      reqDone <= frameEnd;
      if (frameEnd) begin
        reqExecute <= execNow;
        reqFlags   <= curFlags;
      end
    end
  end

  // Software triggers the reply; start is dropped while one is going out
  assign startResp = doWrite && awAddr_q == ADDR_W'(OFF_RESP) && !txBusy && wStrb_q[0];

  resp_composer u_comp (
    .clock   (clock),
    .rstn    (rstn),
    .start   (startResp),
    .isError (wData_q[8]),
    .errCode (wData_q[7:0]),
    .txReady (txReady),
    .txValid (txValid),
    .txByte  (txByte),
    .txLast  (txLast),
    .busy    (txBusy)
  );

  // Interrupts: set wins over a clear in the same cycle
  always_comb begin
    intEvt             = '0;
    intEvt[IRQ_DONE]   = frameEnd;
    intEvt[IRQ_SILENT] = frameEnd && !execNow;
    intEvt[IRQ_FORMAT] = frameEnd && fmtErr;
    intEvt[IRQ_SENT]   = txValid && txReady && txLast;
    intClr             = '0;
    if (doWrite && awAddr_q == ADDR_W'(OFF_INT_STAT) && wStrb_q[0])
      intClr = wData_q[IRQ_W-1:0];
    intStat_d = (intStat_q & ~intClr) | intEvt;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      intStat_q <= '0;
      irq       <= 1'b0;
    end else begin
      intStat_q <= intStat_d;
      irq       <= |(intStat_d & intMask_q);
    end
  end

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  // Write channel: address and data taken in either order
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      awAddr_q      <= '0;
      wData_q       <= 32'h0;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q      <= 1'b1;
        awAddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!awHeld_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q      <= 1'b1;
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!wHeld_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_q[1:0] == 2'b00 && awAddr_q[ADDR_W-1:5] == '0)
                        ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_q    <= CTRL_RST;
      uidLo_q   <= 32'h0;
      uidHi_q   <= 32'h0;
      intMask_q <= MASK_RST;
    end else if (doWrite && awAddr_q[ADDR_W-1:5] == '0) begin
      unique case (awAddr_q[7:0])
        OFF_CTRL:     ctrl_q    <= merge(ctrl_q, wData_q, wStrb_q) & 32'h1;
        OFF_UID_LO:   uidLo_q   <= merge(uidLo_q, wData_q, wStrb_q);
        OFF_UID_HI:   uidHi_q   <= merge(uidHi_q, wData_q, wStrb_q);
        OFF_INT_MASK: if (wStrb_q[0]) intMask_q <= wData_q[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0;
      if (s_axi_araddr[ADDR_W-1:5] != '0 || s_axi_araddr[1:0] != 2'b00)
        s_axi_rresp <= RESP_SLVERR;
      else
        unique case (s_axi_araddr[4:0])
          OFF_CTRL[4:0]:     s_axi_rdata <= ctrl_q;
          OFF_UID_LO[4:0]:   s_axi_rdata <= uidLo_q;
          OFF_UID_HI[4:0]:   s_axi_rdata <= uidHi_q;
          OFF_REQ[4:0]:      s_axi_rdata <= {8'h00, afi_q, reqCommand, rawFlags_q};
          OFF_DECODE[4:0]:   s_axi_rdata <= {16'h0, 1'b0,
                                             reqFlags.slot_count_bit ? 3'h0 : SLOT_CNT_BITS,
                                             txBusy, uidOk_q, reqExecute, reqFlags};
          OFF_INT_STAT[4:0]: s_axi_rdata <= {28'h0, intStat_q};
          OFF_INT_MASK[4:0]: s_axi_rdata <= {28'h0, intMask_q};
          default:           s_axi_rdata <= 32'h0;
        endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  property p_uidMismatchSilent;
    @(posedge clock) disable iff (!rstn)
      frameEnd && curFlags.addressed && !uidOk_q |=> !reqExecute;
  endproperty
  a_uidMismatchSilent: assert property (p_uidMismatchSilent)
    else $error("executed despite identifier mismatch");

  property p_selectNeedsState;
    @(posedge clock) disable iff (!rstn)
      frameEnd && curFlags.selectOnly && !ctrl_q[0] |=> reqDone && !reqExecute;
  endproperty
  a_selectNeedsState: assert property (p_selectNeedsState)
    else $error("select request executed while not selected");

  property p_plainExecutes;
    @(posedge clock) disable iff (!rstn)
      frameEnd && pstate_q == P_PARAM && !curFlags.inventory
        && !rawFlags_q[BIT_SEL_AFI] && !rawFlags_q[BIT_ADDR_SLOTS] |=> reqExecute;
  endproperty
  a_plainExecutes: assert property (p_plainExecutes)
    else $error("non-addressed request not executed");

  property p_inventoryFields;
    @(posedge clock) disable iff (!rstn)
      curFlags.inventory |-> !curFlags.selectOnly && !curFlags.addressed
        && curFlags.family_id_present_bit == rawFlags_q[BIT_SEL_AFI]
        && curFlags.slot_count_bit == rawFlags_q[BIT_ADDR_SLOTS];
  endproperty
  a_inventoryFields: assert property (p_inventoryFields)
    else $error("inventory bits misread");

  property p_optionNonInventory;
    @(posedge clock) disable iff (!rstn)
      curFlags.optionOn |-> !curFlags.inventory && rawFlags_q[BIT_OPTION];
  endproperty
  a_optionNonInventory: assert property (p_optionNonInventory)
    else $error("option taken in inventory request");

  property p_uidWalk;
    @(posedge clock) disable iff (!rstn)
      pstate_q == P_CMD && rxValid && !rxSof && !rxEof && curFlags.addressed
        |=> pstate_q == P_UID && uidIdx_q == 3'h0;
  endproperty
  a_uidWalk: assert property (p_uidWalk)
    else $error("identifier field not entered after command");

  property p_irqFollows;
    @(posedge clock) disable iff (!rstn)
      |(intStat_q & ~intClr & intMask_q) |=> irq;
  endproperty
  a_irqFollows: assert property (p_irqFollows)
    else $error("interrupt not raised for pending status");

  property p_bvalidHeld;
    @(posedge clock) disable iff (!rstn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalidHeld: assert property (p_bvalidHeld)
    else $error("write response dropped early");

  c_executed: cover property (@(posedge clock) disable iff (!rstn) reqDone && reqExecute);
  c_silent:   cover property (@(posedge clock) disable iff (!rstn) reqDone && !reqExecute);
  c_irq:      cover property (@(posedge clock) disable iff (!rstn) $rose(irq));
endmodule

//--- verification/rf_reader_model.sv
`timescale 1ns/100ps
module rf_reader_model (
  input  wire logic       clock,
  input  wire logic       slow,
  output logic            rxSof,
  output logic            rxEof,
  output logic            rxValid,
  output logic [7:0]      rxByte,
  input  wire logic       txValid,
  input  wire logic [7:0] txByte,
  input  wire logic       txLast,
  output logic            txReady
);
  logic [8:0] got[$];
  initial begin
    rxSof   = 1'b0;
    rxEof   = 1'b0;
    rxValid = 1'b0;
    rxByte  = 8'h00;
    txReady = 1'b1;
  end
  task putByte(input logic [7:0] b);
    rxByte  <= b;
    rxValid <= 1'b1;
    @(posedge clock);
  endtask
  // Start, flags, command, extras low byte first, end
  task sendFrame(input logic [7:0] f, c, input int n, input logic [63:0] x);
    rxSof <= 1'b1;
    @(posedge clock);
    rxSof <= 1'b0;
    putByte(f);
    putByte(c);
    for (int i = 0; i < n; i++)
      putByte(x[8*i +: 8]);
    rxValid <= 1'b0;
    // Stale byte inverted so a sampled idle bus never looks valid
    rxByte  <= ~rxByte;
    rxEof   <= 1'b1;
    @(posedge clock);
    rxEof <= 1'b0;
  endtask
  // Slow sink stalls every other cycle
  always @(posedge clock) begin
    if (txValid && txReady)
      got.push_back({txLast, txByte});
    txReady <= slow ? ~txReady : 1'b1;
  end
endmodule

//--- verification/rf_request_response_flags_bench.sv
`timescale 1ns/100ps
module rf_request_response_flags_bench;
  import rf_flags_pkg::*;
  typedef struct {
    logic [7:0]  f;
    int          n;
    logic [63:0] x;
    logic [8:0]  ef;
    logic        ex;
  } row_t;
  localparam logic [63:0] UID = 64'h0123_4567_89ab_cdef;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, reqDone, reqExecute;
  logic        txReady, txValid, txLast, irq, rxSof, rxEof, rxValid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, d;
  logic [7:0]  reqCommand, txByte, rxByte;
  req_flags_t  reqFlags;
  int          nFail = 0;
  int          checks = 0;
  logic [7:0]  codes[9] = '{ERR_UNKNOWN_CMD, ERR_NO_OPTION, ERR_UNSPECIFIED, ERR_BLOCK_NA,
    ERR_ALREADY_LOCK, ERR_BLOCK_LOCKED, ERR_PROG_FAIL, ERR_LOCK_FAIL, ERR_READ_PROT};
  row_t rows[13] = '{
    '{8'h00, 0, 64'h0, 9'h000, 1'b1},
    '{8'h01, 0, 64'h0, 9'h100, 1'b1},
    '{8'h02, 0, 64'h0, 9'h080, 1'b1},
    '{8'h08, 0, 64'h0, 9'h020, 1'b1},
    '{8'h40, 0, 64'h0, 9'h004, 1'b1},
    '{8'h80, 0, 64'h0, 9'h000, 1'b1},
    '{8'h10, 0, 64'h0, 9'h010, 1'b0},
    '{8'h20, 8, UID, 9'h008, 1'b1},
    '{8'h20, 8, UID ^ 64'h1, 9'h008, 1'b0},
    '{8'h04, 0, 64'h0, 9'h040, 1'b1},
    '{8'h24, 0, 64'h0, 9'h041, 1'b1},
    '{8'h14, 1, 64'h5a, 9'h042, 1'b1},
    '{8'h44, 0, 64'h0, 9'h040, 1'b1}};
  rf_request_response_flags dut (.clock(clock), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rxSof(rxSof), .rxEof(rxEof), .rxValid(rxValid), .rxByte(rxByte),
    .reqFlags(reqFlags), .reqCommand(reqCommand), .reqDone(reqDone),
    .reqExecute(reqExecute), .txReady(txReady), .txValid(txValid), .txByte(txByte),
    .txLast(txLast), .irq(irq));
  rf_reader_model reader (.clock(clock), .slow(slow), .rxSof(rxSof), .rxEof(rxEof),
    .rxValid(rxValid), .rxByte(rxByte), .txValid(txValid), .txByte(txByte),
    .txLast(txLast), .txReady(txReady));
  always #5 clock = ~clock;
  task final_report;
    $display("checks %0d mismatches %0d", checks, nFail);
    if (nFail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chkWord(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      nFail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task axiWr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (n >= 50)
      nFail++;
    chkWord(bresp, er);
    // Idle edge so back-to-back calls never drive a signal twice at once
    @(posedge clock);
  endtask
  task axiRd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] e);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (n >= 50)
      nFail++;
    d = rdata;
    chkWord(rresp, er);
    chkWord(d, e);
    @(posedge clock);
  endtask
  // Flags compared only when the frame is well formed
  task frame(input logic [7:0] f, c, input int n, input logic [63:0] x,
             input logic [8:0] ef, input logic ex, input bit cf);
    int k;
    k = 0;
    reader.sendFrame(f, c, n, x);
    while (reqDone !== 1'b1 && k < 20) begin
      @(negedge clock);
      k++;
    end
    if (k >= 20)
      nFail++;
    if (cf)
      chkWord(reqFlags, ef);
    chkWord(reqExecute, ex);
    @(posedge clock);
  endtask
  task response(input logic [31:0] v, input int n);
    int k;
    k = 0;
    reader.got.delete();
    axiWr(OFF_RESP, v, RESP_OKAY);
    while (reader.got.size() < n && k < 40) begin
      @(posedge clock);
      k++;
    end
    repeat (4) @(posedge clock);
    chkWord(reader.got.size(), n);
  endtask
  initial begin
    #200000;
    nFail++;
    final_report;
  end
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    axiRd(OFF_CTRL, RESP_OKAY, CTRL_RST);
    axiRd(OFF_INT_MASK, RESP_OKAY, {28'h0, MASK_RST});
    axiRd(8'h20, RESP_SLVERR, 32'h0);
    axiWr(8'h24, 32'h1, RESP_SLVERR);
    axiWr(OFF_UID_LO, UID[31:0], RESP_OKAY);
    axiWr(OFF_UID_HI, UID[63:32], RESP_OKAY);
    foreach (rows[i])
      frame(rows[i].f, 8'h20 + i[7:0], rows[i].n, rows[i].x, rows[i].ef, rows[i].ex, 1);
    // Family byte of the earlier inventory row stays until replaced
    axiRd(OFF_REQ, RESP_OKAY, 32'h005a_2c44);
    axiRd(OFF_DECODE, RESP_OKAY, 32'h0000_4640);
    axiWr(OFF_CTRL, 32'h1, RESP_OKAY);
    frame(8'h10, 8'h21, 0, 64'h0, 9'h010, 1'b1, 1);
    axiWr(OFF_INT_STAT, 32'hf, RESP_OKAY);
    // Reader breaks the select/address pairing on purpose
    frame(8'h30, 8'h22, 0, 64'h0, 9'h0, 1'b0, 0);
    axiRd(OFF_INT_STAT, RESP_OKAY, 32'h0000_0007);
    frame(8'h20, 8'h23, 3, UID, 9'h0, 1'b0, 0);
    axiWr(OFF_INT_STAT, 32'hf, RESP_OKAY);
    axiWr(OFF_INT_MASK, 32'h1, RESP_OKAY);
    chkWord(irq, 1'b0);
    frame(8'h00, 8'h24, 0, 64'h0, 9'h000, 1'b1, 1);
    repeat (2) @(posedge clock);
    chkWord(irq, 1'b1);
    axiWr(OFF_INT_STAT, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clock);
    chkWord(irq, 1'b0);
    foreach (codes[i]) begin
      slow <= i[0];
      response({23'h0, 1'b1, codes[i]}, 2);
      chkWord(reader.got[0], {1'b0, RESP_ERR_BYTE});
      chkWord(reader.got[1], {1'b1, codes[i]});
    end
    response(32'h0, 1);
    chkWord(reader.got[0], {1'b1, RESP_OK_BYTE});
    axiRd(OFF_RESP, RESP_OKAY, 32'h0);
    final_report;
  end
endmodule
